// >>> core/sdil_pkg.sv
package sdil_pkg;
	// ****************************************
	// word and buffer shape
	// ****************************************
	localparam int SDIL_WORD_W     = 12;
	localparam int SDIL_FIFO_DEPTH = 16;
	localparam int SDIL_FIFO_W     = 1;
	// ****************************************
	// pin vector layout
	// ****************************************
	localparam int SDIL_NPIN   = 7;
	localparam int SDIL_NSTB   = 4;
	localparam int SDIL_PIN_RA = 0;
	localparam int SDIL_PIN_RB = 1;
	localparam int SDIL_PIN_FN = 2;
	localparam int SDIL_PIN_RC = 3;
	localparam int SDIL_PIN_SI = 4;
	localparam int SDIL_PIN_LA = 5;
	localparam int SDIL_PIN_LB = 6;
	// idle levels: rising strobes low, falling strobe high, loads high
	localparam logic [6:0] SDIL_PIN_IDLE = 7'h64;
	// strobes whose active level is low
	localparam logic [3:0] SDIL_STB_INV  = 4'h4;
	localparam logic [3:0] SDIL_STB_NONE = 4'h0;
	localparam logic [3:0] SDIL_STB_ONE  = 4'h1;
	// ****************************************
	// reset values
	// ****************************************
	localparam logic [11:0] SDIL_DAC_RST  = 12'h000;
	localparam logic [11:0] SDIL_DAC_ZERO = 12'h000;
	localparam logic [11:0] SDIL_SR_RST   = 12'h000;
endpackage : sdil_pkg

// >>> core/sdil_stream_if.sv
`timescale 1ns/10ps
interface sdil_stream_if #(
	parameter int W = 1
);
	logic         valid;
	logic         ready;
	logic [W-1:0] data;

	// producer side of a stream
	modport src (
		output valid,
		output data,
		input  ready
	);
	// consumer side of a stream
	modport snk (
		input  valid,
		input  data,
		output ready
	);
endinterface : sdil_stream_if

// >>> core/sdil_fifo.sv
`timescale 1ns/10ps
module sdil_fifo #(
	parameter int W = 1,
	parameter int D = 16
) (
	input wire logic   ref_clk,
	input wire logic   rst,
	sdil_stream_if.snk in_s,
	sdil_stream_if.src out_s
);
	localparam int AW = $clog2(D);
	localparam logic [AW:0] FULL_CNT = AW'(D) == '0 ? {1'b1, {AW{1'b0}}} : (AW+1)'(D);

	logic [W-1:0]  mem [D];
	logic [AW-1:0] wr_ff;
	logic [AW-1:0] rd_ff;
	logic [AW:0]   cnt_ff;
	logic          push;
	logic          pop;

	// handshakes; full and empty come straight from the count
	assign in_s.ready  = (cnt_ff != FULL_CNT);
	assign out_s.valid = (cnt_ff != '0);
	assign out_s.data  = mem[rd_ff];
	assign push        = in_s.valid && in_s.ready;
	assign pop         = out_s.valid && out_s.ready;

	// storage, no reset needed since reads are gated by count
	always_ff @(posedge ref_clk) begin
		if (push) begin
			mem[wr_ff] <= in_s.data;
		end
	end

	// write pointer wraps, depth is a power of two
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			wr_ff <= '0;
		end else if (push) begin
			wr_ff <= wr_ff + AW'(1);
		end
	end

	// read pointer
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			rd_ff <= '0;
		end else if (pop) begin
			rd_ff <= rd_ff + AW'(1);
		end
	end

	// occupancy, simultaneous push and pop leave it unchanged
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			cnt_ff <= '0;
		end else if (push && !pop) begin
			cnt_ff <= cnt_ff + (AW+1)'(1);
		end else if (pop && !push) begin
			cnt_ff <= cnt_ff - (AW+1)'(1);
		end
	end
endmodule : sdil_fifo

// >>> core/sdil_serial_dac_input_logic.sv
`timescale 1ns/10ps
module sdil_serial_dac_input_logic
	import sdil_pkg::*;
(
	input  wire logic                   ref_clk,
	input  wire logic                   rst,
	input  wire logic                   rise_strobe_a,
	input  wire logic                   rise_strobe_b,
	input  wire logic                   fall_strobe_n,
	input  wire logic                   rise_strobe_c,
	input  wire logic                   load_a_n,
	input  wire logic                   load_b_n,
	input  wire logic                   output_zero_n,
	input  wire logic                   serial_in,
	output logic                        serial_chain_out,
	output logic [SDIL_WORD_W-1:0]      dac_code,
	output logic                        accept_ready
);
	// ****************************************
	// declarations
	// ****************************************
	logic [SDIL_NPIN-1:0]   pin_raw;
	logic [SDIL_NPIN-1:0]   pin_f;
	logic [SDIL_NPIN-1:0]   pin_p_ff;
	logic [SDIL_NSTB-1:0]   act_now;
	logic [SDIL_NSTB-1:0]   act_prev;
	logic                   one_hot;
	logic                   shift_evt;
	logic                   load_req;
	logic                   load_go;
	logic                   pop;
	logic [SDIL_WORD_W-1:0] shift_ff;
	logic [SDIL_WORD_W-1:0] dac_ff;

	sdil_stream_if #(.W(SDIL_FIFO_W)) s_in ();
	sdil_stream_if #(.W(SDIL_FIFO_W)) s_out ();

	// ****************************************
	// pin capture
	// ****************************************
	// strobes are never used as clocks: every strobe, data and load pin is oversampled by ref_clk,
	// so a strobe pulse must last at least two ref_clk periods to be seen;
	// shorter pulses are dropped by the filter like glitches
	// gather the asynchronous pins into one vector
	assign pin_raw[SDIL_PIN_RA] = rise_strobe_a;
	assign pin_raw[SDIL_PIN_RB] = rise_strobe_b;
	assign pin_raw[SDIL_PIN_FN] = fall_strobe_n;
	assign pin_raw[SDIL_PIN_RC] = rise_strobe_c;
	assign pin_raw[SDIL_PIN_SI] = serial_in;
	assign pin_raw[SDIL_PIN_LA] = load_a_n;
	assign pin_raw[SDIL_PIN_LB] = load_b_n;

	// three stages per pin; a level counts once stages two and three agree,
	// so data and strobes share one latency and stay aligned
	genvar gi;
	generate
		for (gi = 0; gi < SDIL_NPIN; gi++) begin : g_sync
			logic s1_ff;
			logic s2_ff;
			logic s3_ff;
			logic f_ff;

			always_ff @(posedge ref_clk or posedge rst) begin
				if (rst) begin
					s1_ff <= SDIL_PIN_IDLE[gi];
					s2_ff <= SDIL_PIN_IDLE[gi];
					s3_ff <= SDIL_PIN_IDLE[gi];
				end else begin
					s1_ff <= pin_raw[gi];
					s2_ff <= s1_ff;
					s3_ff <= s2_ff;
				end
			end

			// agreement filter on the settled stages only
			always_ff @(posedge ref_clk or posedge rst) begin
				if (rst) begin
					f_ff <= SDIL_PIN_IDLE[gi];
				end else if (s2_ff == s3_ff) begin
					f_ff <= s3_ff;
				end
			end

			assign pin_f[gi] = f_ff;
		end
	endgenerate

	// previous filtered levels for edge finding
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			pin_p_ff <= SDIL_PIN_IDLE;
		end else begin
			pin_p_ff <= pin_f;
		end
	end

	// ****************************************
	// strobe decode
	// ****************************************
	// active-level view: one means the strobe sits at its shifting level
	// the falling strobe is flipped here so all four are treated alike;
	// one_hot is the x & (x - 1) test for a single set bit
	assign act_now  = pin_f[SDIL_NSTB-1:0] ^ SDIL_STB_INV;
	assign act_prev = pin_p_ff[SDIL_NSTB-1:0] ^ SDIL_STB_INV;
	assign one_hot  = (act_now != SDIL_STB_NONE)
		&& ((act_now & (act_now - SDIL_STB_ONE)) == SDIL_STB_NONE);

	// held strobe blocks
	// a shift needs all strobes idle before and exactly one active after;
	// a strobe still held active keeps act_prev nonzero and blocks it
	assign shift_evt = (act_prev == SDIL_STB_NONE) && one_hot;

	// ****************************************
	// bit buffer
	// ****************************************
	// bits that arrive while full are lost; accept_ready warns the host
	// the buffer lets strobe edges run ahead of a stalled shift register;
	// sixteen bits cover one word plus slack while the loads are held low
	assign s_in.valid   = shift_evt;
	assign s_in.data    = pin_f[SDIL_PIN_SI];
	assign accept_ready = s_in.ready;

	sdil_fifo #(
		.W (SDIL_FIFO_W),
		.D (SDIL_FIFO_DEPTH)
	) u_fifo (
		.ref_clk (ref_clk),
		.rst     (rst),
		.in_s    (s_in),
		.out_s   (s_out)
	);

	// ****************************************
	// input shift register
	// ****************************************
	assign load_req = !pin_f[SDIL_PIN_LA] && !pin_f[SDIL_PIN_LB];

	// loads stall shifting
	// draining stops during a load so the copied word cannot move
	assign s_out.ready = !load_req;
	assign pop         = s_out.valid && s_out.ready;

	// draining runs one bit per ref_clk, far faster than any legal strobe,
	// so in normal use the buffer never holds more than one bit
	// MSB first
	// clear not involved
	// bits enter at the LSB and walk up, so the first one ends in the MSB;
	// clear is deliberately absent here
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			shift_ff <= SDIL_SR_RST;
		end else if (pop) begin
			shift_ff <= {shift_ff[SDIL_WORD_W-2:0], s_out.data};
		end
	end

	// twelve stage chain
	// the MSB leaves the chain, eleven shifts after it entered
	assign serial_chain_out = shift_ff[SDIL_WORD_W-1];

	// ****************************************
	// DAC register
	// ****************************************
	// host keeps order
	// copy waits until all buffered bits have reached the shift register
	assign load_go = load_req && !s_out.valid;

	// async clear
	// clear acts without the clock and wins over any load
	// clear bypasses the synchronisers on purpose; its release is
	// asynchronous, so a load right at release may land a cycle early or late
	always_ff @(posedge ref_clk or posedge rst or negedge output_zero_n) begin
		if (rst) begin
			dac_ff <= SDIL_DAC_RST;
		end else if (!output_zero_n) begin
			dac_ff <= SDIL_DAC_ZERO;
		end else if (load_go) begin
			dac_ff <= shift_ff;
		end
	end

	assign dac_code = dac_ff;

	// ****************************************
	// assertions
	// ****************************************
	// properties watch the filtered pin view (output_zero_n is read raw), so every check counts ref_clk
	// cycles and the pin-to-event latency stays out of them
	// rising strobes push
	AST_RISE_SHIFT: assert property (@(posedge ref_clk) disable iff (rst)
		(act_prev == SDIL_STB_NONE) && (act_now == 4'h1 || act_now == 4'h2 || act_now == 4'h8)
		|-> s_in.valid && s_in.data == pin_f[SDIL_PIN_SI])
		else $error("rising strobe edge did not push a bit");

	AST_FALL_SHIFT: assert property (@(posedge ref_clk) disable iff (rst)
		$fell(pin_f[SDIL_PIN_FN]) && pin_f[SDIL_PIN_RA] == 1'b0
		&& pin_f[SDIL_PIN_RB] == 1'b0 && pin_f[SDIL_PIN_RC] == 1'b0
		&& $past(pin_f[SDIL_PIN_RA]) == 1'b0 && $past(pin_f[SDIL_PIN_RB]) == 1'b0
		&& $past(pin_f[SDIL_PIN_RC]) == 1'b0 |-> s_in.valid)
		else $error("falling strobe edge did not push a bit");

	AST_IDLE_ONLY: assert property (@(posedge ref_clk) disable iff (rst)
		s_in.valid |-> pin_p_ff[SDIL_NSTB-1:0] == SDIL_PIN_IDLE[SDIL_NSTB-1:0]
		&& $countones(act_now) == 1)
		else $error("push while another strobe was not idle");

	AST_HOLD_BLOCK: assert property (@(posedge ref_clk) disable iff (rst)
		act_prev != SDIL_STB_NONE |-> !s_in.valid)
		else $error("bit accepted while a strobe was held active");

	AST_MSB_FIRST: assert property (@(posedge ref_clk) disable iff (rst)
		pop |=> shift_ff[0] == $past(s_out.data)
		&& shift_ff[SDIL_WORD_W-1:1] == $past(shift_ff[SDIL_WORD_W-2:0]))
		else $error("shift register did not move toward the MSB");

	AST_CHAIN: assert property (@(posedge ref_clk) disable iff (rst)
		pop ##1 !pop |-> serial_chain_out == $past(shift_ff[SDIL_WORD_W-2]) ##1
		serial_chain_out == $past(serial_chain_out))
		else $error("chain output out of step with shifting");

	AST_LOAD: assert property (@(posedge ref_clk) disable iff (rst)
		(load_go && output_zero_n) ##1 output_zero_n |-> dac_code == $past(shift_ff))
		else $error("DAC register missed the parallel load");

	AST_KEEP: assert property (@(posedge ref_clk) disable iff (rst)
		(!load_req && output_zero_n) ##1 output_zero_n |-> $stable(dac_code))
		else $error("DAC register changed without both loads");

	AST_CLEAR: assert property (@(posedge ref_clk) disable iff (rst)
		!output_zero_n |-> dac_code == SDIL_DAC_ZERO)
		else $error("DAC register not zero during clear");

	AST_CLR_KEEPS: assert property (@(posedge ref_clk) disable iff (rst)
		!output_zero_n && !pop |=> $stable(shift_ff) && $stable(serial_chain_out))
		else $error("clear disturbed the input register");

	AST_NO_SHIFT_LOAD: assert property (@(posedge ref_clk) disable iff (rst)
		load_req |-> !pop)
		else $error("shift register moved during a load");

	AST_LOAD_FREEZE: assert property (@(posedge ref_clk) disable iff (rst)
		load_req |=> $stable(shift_ff))
		else $error("input register changed while loads were low");

	AST_LOAD_WAIT: assert property (@(posedge ref_clk) disable iff (rst)
		(load_req && s_out.valid && output_zero_n) ##1 output_zero_n |-> $stable(dac_code))
		else $error("DAC register loaded before the buffer drained");

	AST_TWO_REFUSED: assert property (@(posedge ref_clk) disable iff (rst)
		(act_prev == SDIL_STB_NONE) && ($countones(act_now) > 1) |-> !s_in.valid)
		else $error("push when two strobes went active together");

	AST_CHAIN_HOLD: assert property (@(posedge ref_clk) disable iff (rst)
		!pop |=> $stable(serial_chain_out) && $stable(shift_ff))
		else $error("input register moved without a shift");

	// main scenarios
	COV_RISE: cover property (@(posedge ref_clk) disable iff (rst)
		s_in.valid && act_now == 4'h1);
	COV_FALL: cover property (@(posedge ref_clk) disable iff (rst)
		s_in.valid && act_now == SDIL_STB_INV);
	COV_LOAD: cover property (@(posedge ref_clk) disable iff (rst)
		load_go && output_zero_n && shift_ff != SDIL_SR_RST);
	COV_FULL: cover property (@(posedge ref_clk) disable iff (rst)
		!s_in.ready);
	COV_DRAIN: cover property (@(posedge ref_clk) disable iff (rst)
		pop ##1 pop);
endmodule : sdil_serial_dac_input_logic

// >>> tb/sdil_host_model.sv
`timescale 1ns/10ps
module sdil_host_model
	import sdil_pkg::*;
(
	input  wire logic ref_clk,
	output logic      rise_strobe_a,
	output logic      rise_strobe_b,
	output logic      fall_strobe_n,
	output logic      rise_strobe_c,
	output logic      load_a_n,
	output logic      load_b_n,
	output logic      output_zero_n,
	output logic      serial_in
);
	// ****************************************
	// strobe pins
	// ****************************************
	logic [3:0] act_ff;
	// active flags to pin levels; falling strobe idles high
	assign {rise_strobe_c, fall_strobe_n, rise_strobe_b, rise_strobe_a} = act_ff ^ SDIL_STB_INV;
	// idle levels at time zero
	initial begin
		act_ff        = SDIL_STB_NONE;
		serial_in     = 1'b0;
		load_a_n      = 1'b1;
		load_b_n      = 1'b1;
		output_zero_n = 1'b1;
	end
	task automatic wait_clk(input int n);
		repeat (n) @(posedge ref_clk);
	endtask : wait_clk
	// one 200 ns link period; data set 75 ns before the edge, held past it
	// one strobe per bit
	task automatic put_bit(input int s, input logic b);
		wait_clk(1);
		serial_in <= b;
		wait_clk(3);
		act_ff[s] <= 1'b1;
		wait_clk(4);
		act_ff[s] <= 1'b0;
	endtask : put_bit
	task automatic put_word(input int s, input logic [11:0] w);
		for (int i = 11; i >= 0; i--) begin
			put_bit(s, w[i]);
		end
		wait_clk(4);
		// line flipped: the last bit is not held after the frame
		serial_in <= ~serial_in;
	endtask : put_word
	task automatic set_act(input int s, input logic v, input logic b);
		wait_clk(1);
		serial_in <= b;
		wait_clk(4);
		act_ff[s] <= v;
		// keep data steady past the edge before anything else moves
		wait_clk(4);
	endtask : set_act
	task automatic set_loads(input logic a, input logic b);
		wait_clk(1);
		load_a_n <= a;
		load_b_n <= b;
	endtask : set_loads
	task automatic set_clear(input logic v);
		wait_clk(1);
		output_zero_n <= v;
	endtask : set_clear
endmodule : sdil_host_model

// >>> tb/tb_top.sv
`timescale 1ns/10ps
module tb_top
	import sdil_pkg::*;
;
	logic        ref_clk;
	logic        rst;
	wire logic        ra, rb, fn, rc, la, lb, clr_n, sin;
	wire logic        chain;
	wire logic [11:0] dac;
	wire logic        rdy;
	int          err_count;
	int          tests_run;
	int          cyc;
	logic [11:0] cur;
	sdil_host_model u_host (.ref_clk(ref_clk), .rise_strobe_a(ra), .rise_strobe_b(rb), .fall_strobe_n(fn),
		.rise_strobe_c(rc), .load_a_n(la), .load_b_n(lb), .output_zero_n(clr_n), .serial_in(sin));
	sdil_serial_dac_input_logic uut (.ref_clk(ref_clk), .rst(rst), .rise_strobe_a(ra), .rise_strobe_b(rb),
		.fall_strobe_n(fn), .rise_strobe_c(rc), .load_a_n(la), .load_b_n(lb), .output_zero_n(clr_n),
		.serial_in(sin), .serial_chain_out(chain), .dac_code(dac), .accept_ready(rdy));
	// ****************************************
	// clock, timeout, report
	// ****************************************
	initial ref_clk = 1'b0;
	always #12.5 ref_clk = ~ref_clk;
	// ceiling well above the roughly 1100 cycles the tests need
	always @(posedge ref_clk) begin
		cyc++;
		if (cyc == 20000) begin
			err_count++;
			finish_test();
		end
	end
	task automatic finish_test();
		$display("checks %0d mismatches %0d", tests_run, err_count);
		if (err_count == 0 && tests_run > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask : finish_test
	task automatic chk_w(input logic [11:0] got, input logic [11:0] exp, input string m);
		tests_run++;
		if (got !== exp) begin
			err_count++;
			$display("BAD %0t %s got %h want %h", $time, m, got, exp);
		end
	endtask : chk_w
	task automatic chk_b(input logic got, input logic exp, input string m);
		tests_run++;
		if (got !== exp) begin
			err_count++;
			$display("BAD %0t %s got %b want %b", $time, m, got, exp);
		end
	endtask : chk_b
	// loads low long enough for the filter, then back to idle
	task automatic do_load(input logic [11:0] exp);
		u_host.set_loads(1'b0, 1'b0);
		u_host.wait_clk(8);
		chk_w(dac, exp, "loaded word");
		u_host.set_loads(1'b1, 1'b1);
		u_host.wait_clk(6);
	endtask : do_load
	// ****************************************
	// scenarios
	// ****************************************
	task automatic t_strobes();
		logic [11:0] w [4] = '{12'hA5C, 12'h3E1, 12'h801, 12'hFFE};
		for (int s = 0; s < 4; s++) begin
			u_host.put_word(s, w[s]);
			do_load(w[s]);
		end
		cur = w[3];
		$display("test strobes done");
	endtask : t_strobes
	task automatic t_chain();
		logic [11:0] nw = 12'h6B4;
		for (int i = 11; i >= 0; i--) begin
			chk_b(chain, cur[i], "chain bit");
			u_host.put_bit(1, nw[i]);
			u_host.wait_clk(3);
		end
		chk_b(chain, nw[11], "chain new msb");
		do_load(nw);
		cur = nw;
		$display("test chain done");
	endtask : t_chain
	task automatic t_hold();
		for (int k = 0; k < 2; k++) begin
			u_host.set_loads(k[0], ~k[0]);
			u_host.put_word(3, 12'h0F0 ^ k[11:0]);
			u_host.wait_clk(8);
			chk_w(dac, cur, "one load high");
			u_host.set_loads(1'b1, 1'b1);
		end
		cur = 12'h0F1;
		$display("test hold done");
	endtask : t_hold
	// a held strobe takes its own edge, then blocks every other strobe
	task automatic t_block();
		u_host.set_act(1, 1'b1, 1'b1);
		u_host.put_bit(0, 1'b0);
		u_host.put_bit(2, 1'b0);
		u_host.put_bit(3, 1'b0);
		u_host.set_act(1, 1'b0, 1'b1);
		u_host.wait_clk(4);
		cur = {cur[10:0], 1'b1};
		do_load(cur);
		$display("test block done");
	endtask : t_block
	task automatic t_clear();
		u_host.set_clear(1'b0);
		#1;
		chk_w(dac, SDIL_DAC_ZERO, "clear at once");
		u_host.set_loads(1'b0, 1'b0);
		u_host.wait_clk(8);
		chk_w(dac, SDIL_DAC_ZERO, "clear over load");
		u_host.set_loads(1'b1, 1'b1);
		u_host.wait_clk(6);
		u_host.set_clear(1'b1);
		u_host.wait_clk(6);
		chk_w(dac, SDIL_DAC_ZERO, "zero kept after clear");
		chk_b(chain, cur[11], "chain kept");
		do_load(cur);
		$display("test clear done");
	endtask : t_clear
	// loads low stall draining, so sixteen bits fill the buffer
	task automatic t_fifo();
		logic [15:0] v = 16'h9C35;
		u_host.set_loads(1'b0, 1'b0);
		u_host.wait_clk(8);
		for (int i = 15; i >= 0; i--) begin
			u_host.put_bit(3, v[i]);
		end
		u_host.wait_clk(4);
		chk_b(rdy, 1'b0, "buffer full");
		u_host.set_loads(1'b1, 1'b1);
		u_host.wait_clk(30);
		chk_b(rdy, 1'b1, "buffer drained");
		do_load(v[11:0]);
		$display("test fifo done");
	endtask : t_fifo
	initial begin
		err_count = 0;
		tests_run = 0;
		cyc = 0;
		rst = 1'b1;
		repeat (8) @(posedge ref_clk);
		rst <= 1'b0;
		u_host.wait_clk(6);
		chk_w(dac, SDIL_DAC_RST, "reset value");
		t_strobes();
		t_chain();
		t_hold();
		t_block();
		t_clear();
		t_fifo();
		finish_test();
	end
endmodule : tb_top
